// *** two_wire_pkg.sv ***
package two_wire_pkg;
  // Link sampling clock period; the bench runs the link clock at 80 ns.
  localparam int LINK_PERIOD_PS              = 80000;
  // Longest spike that must be rejected, standard and fast mode.
  localparam int GLITCH_REJECT_TIME_STD_NS   = 100;
  localparam int GLITCH_REJECT_TIME_FAST_NS  = 50;
  // A spike can cover ceil(t/T) samples, so one sample more must agree.
  localparam int GLITCH_STD_CYC  = (GLITCH_REJECT_TIME_STD_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS + 1;
  localparam int GLITCH_FAST_CYC = (GLITCH_REJECT_TIME_FAST_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS + 1;
  localparam int BYTE_W          = 8;
  localparam int FIFO_DEPTH      = 32;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic LINE_RESET    = 1'b1;

  typedef struct packed {
    logic             first;
    logic [BYTE_W-1:0] data;
  } link_word_s;

  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_RECV    = 6'h02,
    ST_ACK_OUT = 6'h04,
    ST_SEND    = 6'h08,
    ST_ACK_IN  = 6'h10,
    ST_WAIT    = 6'h20
  } link_state_e;
endpackage : two_wire_pkg

// *** line_filter.sv ***
`timescale 1ns/1ns
module line_filter #(
  parameter int STD_CYC  = two_wire_pkg::GLITCH_STD_CYC,
  parameter int FAST_CYC = two_wire_pkg::GLITCH_FAST_CYC
) (
  // Clock and reset.
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Line.
  input  wire logic pin_in,
  input  wire logic fast_in,
  output logic      level_out
);
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic       sync0;
  logic       sync1;
  logic       next_level;
  logic [3:0] limit;

  always_comb begin
    limit      = fast_in ? 4'(FAST_CYC) : 4'(STD_CYC);
    next_cnt   = 4'h0;
    next_level = level_out;
    if (sync1 != level_out) begin
      next_cnt = cnt + 4'h1;
      if (next_cnt >= limit) begin
        next_level = sync1;
        next_cnt   = 4'h0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync0     <= two_wire_pkg::LINE_RESET;
      sync1     <= two_wire_pkg::LINE_RESET;
      level_out <= two_wire_pkg::LINE_RESET;
      cnt       <= 4'h0;
    end else begin
      sync0     <= pin_in;
      sync1     <= sync0;
      level_out <= next_level;
      cnt       <= next_cnt;
    end
  end

  glitch_reject_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R9
    $changed(level_out) |-> $past(sync1, 1) == level_out && $past(sync1, 2) == level_out)
    else $error("filtered line changed on a short spike");
endmodule : line_filter

// *** cross_fifo.sv ***
`timescale 1ns/1ns
module cross_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = two_wire_pkg::FIFO_DEPTH,
  parameter int AW    = $clog2(DEPTH)
) (
  // Write side.
  input  wire logic             wr_clk_in,
  input  wire logic             wr_rst_n_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  input  wire logic [WIDTH-1:0] wr_data_in,
  // Read side.
  input  wire logic             rd_clk_in,
  input  wire logic             rd_rst_n_in,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in,
  output logic      [WIDTH-1:0] rd_data_out
);
  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction : to_gray

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wbin;
  logic [AW:0]      rbin;
  logic [AW:0]      wgray;
  logic [AW:0]      rgray;
  logic [AW:0]      rq1;
  logic [AW:0]      rq2;
  logic [AW:0]      wq1;
  logic [AW:0]      wq2;
  logic             push;
  logic             pop;

  // Full compares gray codes so only the two top bits differ.
  assign wr_ready_out = wgray != {~rq2[AW:AW-1], rq2[AW-2:0]};
  assign push         = wr_valid_in && wr_ready_out;
  assign pop          = (rgray != wq2) && (!rd_valid_out || rd_ready_in);

  always_ff @(posedge wr_clk_in) begin
    if (push) begin
      mem[wbin[AW-1:0]] <= wr_data_in;
    end
  end

  always_ff @(posedge wr_clk_in or negedge wr_rst_n_in) begin
    if (!wr_rst_n_in) begin
      wbin  <= '0;
      wgray <= '0;
      rq1   <= '0;
      rq2   <= '0;
    end else begin
      wbin  <= wbin + (AW+1)'(push);
      wgray <= to_gray(wbin + (AW+1)'(push));
      rq1   <= rgray;
      rq2   <= rq1;
    end
  end

  always_ff @(posedge rd_clk_in or negedge rd_rst_n_in) begin
    if (!rd_rst_n_in) begin
      rbin         <= '0;
      rgray        <= '0;
      wq1          <= '0;
      wq2          <= '0;
      rd_valid_out <= 1'b0;
      rd_data_out  <= '0;
    end else begin
      wq1   <= wgray;
      wq2   <= wq1;
      rbin  <= rbin + (AW+1)'(pop);
      rgray <= to_gray(rbin + (AW+1)'(pop));
      if (pop) begin
        rd_data_out  <= mem[rbin[AW-1:0]];
        rd_valid_out <= 1'b1;
      end else if (rd_ready_in) begin
        rd_valid_out <= 1'b0;
      end
    end
  end
endmodule : cross_fifo

// *** two_wire_link.sv ***
`timescale 1ns/1ns
// Summary of operation
// R1 - Sample data on serial clock rise, change driven data on its fall.
// R2 - Bytes travel most significant bit first.
// R3 - Eight data bits then a ninth acknowledge clock per byte.
// R4 - Master gives nine unbroken clocks per byte.
// R5 - Driver changes data only while clock is low.
// R6 - Data change while clock high is Start or Stop, not data.
// R7 - No limit on bytes between Start and Stop.
// R8 - Bus idle only when clock and data both high.
// R9 - Reject spikes up to 100 ns standard, 50 ns fast.
// R10 - Ignore the bus while power-on reset is asserted.
// R11 - Master waits 100 us after stable supply before first command.
// R12 - Data line is only pulled low or released.
// R13 - Master starts every transfer and makes the clock.
// R14 - Start is data falling with clock high, Stop is data rising.
// R15 - Transmitter releases after eighth fall, receiver holds low in ninth.
// R16 - Master no-acknowledge ends sending and releases the line.
// R17 - Up to nine dummy clocks free the data line.
// R18 - Start or Stop mid-byte abandons the byte and releases.
// R19 - Start clears the bit counter.
module two_wire_link (
  // System clock and power-on reset.
  input  wire logic                              ref_clk_in,
  input  wire logic                              rst_n_in,
  // Link sampling clock and bus pins.
  input  wire logic                              link_clk_in,
  input  wire logic                              scl_in,
  input  wire logic                              sda_in,
  output logic                                   sda_out,
  output logic                                   sda_oe_n_out,
  input  wire logic                              fast_mode_in,
  // Received bytes.
  output logic                                   rx_valid_out,
  input  wire logic                              rx_ready_in,
  output logic      [two_wire_pkg::BYTE_W-1:0]   rx_data_out,
  output logic                                   rx_first_out,
  // Bytes to send.
  input  wire logic                              tx_valid_in,
  output logic                                   tx_ready_out,
  input  wire logic [two_wire_pkg::BYTE_W-1:0]   tx_data_in,
  // Status.
  output logic                                   bus_idle_out
);
  // Link domain state.
  two_wire_pkg::link_state_e state;
  two_wire_pkg::link_state_e next_state;
  two_wire_pkg::link_word_s  wr_word;
  two_wire_pkg::link_word_s  rd_word;
  logic [1:0]                link_rst_sync;
  logic                      link_rst_n;
  logic                      fast0;
  logic                      fast1;
  logic                      scl_f;
  logic                      sda_f;
  logic                      scl_p;
  logic                      sda_p;
  logic [3:0]                bit_cnt;
  logic [3:0]                next_bit_cnt;
  logic [7:0]                shift;
  logic [7:0]                next_shift;
  logic                      sda_oe_n;
  logic                      next_sda_oe_n;
  logic                      ack_ok;
  logic                      next_ack_ok;
  logic                      first;
  logic                      next_first;
  logic                      wr_valid;
  logic                      wr_ready;
  logic                      tx_full;
  logic                      next_tx_full;
  logic [7:0]                tx_byte;
  logic [7:0]                next_tx_byte;
  logic                      req_s0;
  logic                      req_s1;
  logic                      req_seen;
  logic                      next_req_seen;
  logic                      idle_level;
  logic                      scl_rise;
  logic                      scl_fall;
  logic                      start;
  logic                      stop;
  // Idle is registered before it crosses, so the synchroniser never catches a gate glitch.
  logic                      bus_free;
  // System domain state.
  logic                      req_tog;
  logic                      next_req_tog;
  logic [7:0]                tx_hold;
  logic [7:0]                next_tx_hold;
  logic                      ack_s0;
  logic                      ack_s1;
  logic                      idle_s0;
  logic                      next_tx_ready;

  // Reset asserts at once but leaves on a link edge, so the engine never
  // sees half a release.
  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      link_rst_sync <= 2'h0;
    end else begin
      link_rst_sync <= {link_rst_sync[0], 1'b1};
    end
  end
  assign link_rst_n = link_rst_sync[1]; // R10

  line_filter u_scl_filter (
    .clk_in    (link_clk_in),
    .rst_n_in  (link_rst_n),
    .pin_in    (scl_in),
    .fast_in   (fast1),
    .level_out (scl_f)
  ); // R9
  line_filter u_sda_filter (
    .clk_in    (link_clk_in),
    .rst_n_in  (link_rst_n),
    .pin_in    (sda_in),
    .fast_in   (fast1),
    .level_out (sda_f)
  ); // R9

  assign scl_rise   = scl_f && !scl_p;
  assign scl_fall   = !scl_f && scl_p;
  assign start      = scl_f && scl_p && sda_p && !sda_f; // R6 R14
  assign stop       = scl_f && scl_p && !sda_p && sda_f; // R6 R14
  assign idle_level = scl_f && sda_f && (state == two_wire_pkg::ST_IDLE); // R8
  assign sda_out    = 1'b0; // R12

  always_comb begin
    next_state    = state;
    next_bit_cnt  = bit_cnt;
    next_shift    = shift;
    next_sda_oe_n = sda_oe_n;
    next_ack_ok   = ack_ok;
    next_first    = first;
    next_tx_full  = tx_full;
    next_tx_byte  = tx_byte;
    next_req_seen = req_seen;
    wr_valid      = 1'b0;
    wr_word       = '{first: first, data: shift};
    if (req_s1 != req_seen && !tx_full) begin
      next_tx_byte  = tx_hold;
      next_tx_full  = 1'b1;
      next_req_seen = req_s1;
    end
    if (start) begin
      next_state    = two_wire_pkg::ST_RECV; // R19
      next_bit_cnt  = 4'h0; // R18 R19
      next_sda_oe_n = 1'b1; // R18
      next_first    = 1'b1;
    end else if (stop) begin
      next_state    = two_wire_pkg::ST_IDLE; // R14
      next_bit_cnt  = 4'h0; // R18
      next_sda_oe_n = 1'b1; // R18
    end else begin
      case (state)
        two_wire_pkg::ST_RECV: begin
          if (scl_rise) begin
            next_shift   = {shift[6:0], sda_f}; // R1 R2
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == two_wire_pkg::ACK_BIT) begin
            // A full queue refuses the byte with a no-acknowledge.
            wr_valid      = wr_ready;
            next_first    = 1'b0;
            next_sda_oe_n = !wr_ready; // R3 R15
            next_state    = two_wire_pkg::ST_ACK_OUT;
          end
        end
        two_wire_pkg::ST_ACK_OUT: begin
          if (scl_fall) begin
            next_bit_cnt = 4'h0;
            if (tx_full) begin
              next_shift    = tx_byte;
              next_tx_full  = 1'b0;
              next_sda_oe_n = tx_byte[7]; // R1 R2 R12
              next_state    = two_wire_pkg::ST_SEND;
            end else begin
              next_sda_oe_n = 1'b1;
              next_state    = two_wire_pkg::ST_RECV; // R7
            end
          end
        end
        two_wire_pkg::ST_SEND: begin
          if (scl_rise) begin
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt == two_wire_pkg::ACK_BIT) begin
              next_sda_oe_n = 1'b1; // R15
              next_state    = two_wire_pkg::ST_ACK_IN;
            end else begin
              next_shift    = {shift[6:0], 1'b0};
              next_sda_oe_n = shift[6]; // R1 R2 R5
            end
          end
        end
        two_wire_pkg::ST_ACK_IN: begin
          if (scl_rise) begin
            next_ack_ok = !sda_f; // R1
          end else if (scl_fall) begin
            next_bit_cnt = 4'h0;
            if (!ack_ok) begin
              next_sda_oe_n = 1'b1; // R16 R17
              next_state    = two_wire_pkg::ST_WAIT;
            end else if (tx_full) begin
              next_shift    = tx_byte;
              next_tx_full  = 1'b0;
              next_sda_oe_n = tx_byte[7];
              next_state    = two_wire_pkg::ST_SEND; // R7
            end else begin
              next_state = two_wire_pkg::ST_RECV;
            end
          end
        end
        default: begin
          next_sda_oe_n = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      state        <= two_wire_pkg::ST_IDLE; // R10
      bit_cnt      <= 4'h0;
      shift        <= 8'h00;
      sda_oe_n     <= two_wire_pkg::LINE_RESET;
      sda_oe_n_out <= two_wire_pkg::LINE_RESET;
      ack_ok       <= 1'b0;
      first        <= 1'b0;
      tx_full      <= 1'b0;
      tx_byte      <= 8'h00;
      req_s0       <= 1'b0;
      req_s1       <= 1'b0;
      req_seen     <= 1'b0;
      fast0        <= 1'b0;
      fast1        <= 1'b0;
      scl_p        <= two_wire_pkg::LINE_RESET;
      sda_p        <= two_wire_pkg::LINE_RESET;
      bus_free     <= 1'b0;
    end else begin
      state        <= next_state;
      bit_cnt      <= next_bit_cnt;
      shift        <= next_shift;
      sda_oe_n     <= next_sda_oe_n;
      sda_oe_n_out <= next_sda_oe_n;
      ack_ok       <= next_ack_ok;
      first        <= next_first;
      tx_full      <= next_tx_full;
      tx_byte      <= next_tx_byte;
      req_s0       <= req_tog;
      req_s1       <= req_s0;
      req_seen     <= next_req_seen;
      fast0        <= fast_mode_in;
      fast1        <= fast0;
      scl_p        <= scl_f;
      sda_p        <= sda_f;
      bus_free     <= idle_level;
    end
  end

  // The queue's read register holds one byte beyond its words, so 33 bytes fit before a refusal.
  cross_fifo #(
    .WIDTH ($bits(two_wire_pkg::link_word_s)),
    .DEPTH (two_wire_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .wr_clk_in    (link_clk_in),
    .wr_rst_n_in  (link_rst_n),
    .wr_valid_in  (wr_valid),
    .wr_ready_out (wr_ready),
    .wr_data_in   (wr_word),
    .rd_clk_in    (ref_clk_in),
    .rd_rst_n_in  (rst_n_in),
    .rd_valid_out (rx_valid_out),
    .rd_ready_in  (rx_ready_in),
    .rd_data_out  (rd_word)
  );
  assign rx_data_out  = rd_word.data;
  assign rx_first_out = rd_word.first;

  // One byte at a time crosses by toggle handshake; the held byte stays
  // still until the link domain echoes the toggle back.
  always_comb begin
    next_req_tog  = req_tog;
    next_tx_hold  = tx_hold;
    if (tx_valid_in && tx_ready_out) begin
      next_tx_hold = tx_data_in;
      next_req_tog = !req_tog;
    end
    next_tx_ready = (next_req_tog == ack_s1);
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_tog      <= 1'b0;
      tx_hold      <= 8'h00;
      ack_s0       <= 1'b0;
      ack_s1       <= 1'b0;
      tx_ready_out <= 1'b0;
      idle_s0      <= 1'b0;
      bus_idle_out <= 1'b0;
    end else begin
      req_tog      <= next_req_tog;
      tx_hold      <= next_tx_hold;
      ack_s0       <= req_seen;
      ack_s1       <= ack_s0;
      tx_ready_out <= next_tx_ready;
      idle_s0      <= bus_free;
      bus_idle_out <= idle_s0; // R8
    end
  end

  change_on_fall_a: assert property (@(posedge link_clk_in) disable iff (!link_rst_n) // R1
    $changed(sda_oe_n) |-> $past(scl_fall) || $past(start) || $past(stop))
    else $error("data line changed away from a clock fall");
  steady_high_a: assert property (@(posedge link_clk_in) disable iff (!link_rst_n) // R5
    (scl_f && scl_p && !start && !stop) |=> $stable(sda_oe_n))
    else $error("data line moved while clock high");
  msb_first_a: assert property (@(posedge link_clk_in) disable iff (!link_rst_n) // R2
    (state == two_wire_pkg::ST_SEND && scl_fall && bit_cnt < 4'h8 && !start && !stop)
      |=> sda_oe_n == $past(shift[6]))
    else $error("sent bit out of order");
  ack_slot_a: assert property (@(posedge link_clk_in) disable iff (!link_rst_n) // R3
    (state == two_wire_pkg::ST_RECV && scl_fall && bit_cnt == 4'h8 && !start && !stop)
      |=> state == two_wire_pkg::ST_ACK_OUT && sda_oe_n == !$past(wr_ready))
    else $error("no acknowledge slot after eight bits");
  bit_range_a: assert property (@(posedge link_clk_in) disable iff (!link_rst_n) // R4
    bit_cnt <= 4'h8)
    else $error("bit counter passed the acknowledge slot");
  start_resync_a: assert property (@(posedge link_clk_in) disable iff (!link_rst_n) // R19
    start |=> state == two_wire_pkg::ST_RECV && bit_cnt == 4'h0 && sda_oe_n ##1 first)
    else $error("start did not restart the byte");
  stop_idle_a: assert property (@(posedge link_clk_in) disable iff (!link_rst_n) // R14
    stop |=> state == two_wire_pkg::ST_IDLE && sda_oe_n)
    else $error("stop did not release the bus");
  release_eighth_a: assert property (@(posedge link_clk_in) disable iff (!link_rst_n) // R15
    (state == two_wire_pkg::ST_SEND && scl_fall && bit_cnt == 4'h8 && !start && !stop)
      |=> sda_oe_n && state == two_wire_pkg::ST_ACK_IN)
    else $error("line not released for the acknowledge");
  nack_release_a: assert property (@(posedge link_clk_in) disable iff (!link_rst_n) // R16
    (state == two_wire_pkg::ST_ACK_IN && scl_fall && !ack_ok && !start && !stop)
      |=> sda_oe_n [*2])
    else $error("sending went on after no-acknowledge");
  drive_state_a: assert property (@(posedge link_clk_in) disable iff (!link_rst_n) // R12
    !sda_oe_n |-> state inside {two_wire_pkg::ST_ACK_OUT, two_wire_pkg::ST_SEND})
    else $error("line pulled low outside a driving state");
endmodule : two_wire_link

// *** two_wire_host.sv ***
`timescale 1ns/1ns
module two_wire_host #(
  parameter int HALF_NS = 600
) (
  // Bus lines.
  output logic      scl_out,
  output logic      sda_drv_out,
  input  wire logic sda_in
);
  // Both lines start released so the bus idles high.
  initial begin
    scl_out     = 1'b1;
    sda_drv_out = 1'b1;
  end

  // One clock period; the data line is read in the middle of the high phase.
  task automatic clock_bit(input logic b, output logic seen);
    #(HALF_NS / 2) sda_drv_out = b;
    #(HALF_NS / 2) scl_out = 1'b1;
    #(HALF_NS / 2) seen = sda_in;
    #(HALF_NS / 2) scl_out = 1'b0;
  endtask : clock_bit

  task automatic start_cond();
    #(HALF_NS / 2) sda_drv_out = 1'b1;
    #(HALF_NS) scl_out = 1'b1;
    #(HALF_NS) sda_drv_out = 1'b0;
    #(HALF_NS) scl_out = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    #(HALF_NS / 2) sda_drv_out = 1'b0;
    #(HALF_NS / 2) scl_out = 1'b1;
    #(HALF_NS) sda_drv_out = 1'b1;
    #(HALF_NS);
  endtask : stop_cond

  task automatic send_bits(input logic [7:0] d, input int n);
    logic seen;
    for (int i = n - 1; i >= 0; i--) begin
      clock_bit(d[i], seen);
    end
  endtask : send_bits

  // Byte and acknowledge slot go out as nine unbroken clocks.
  task automatic write_byte(input logic [7:0] d, output logic ack);
    send_bits(d, 8);
    clock_bit(1'b1, ack);
  endtask : write_byte

  task automatic read_byte(input logic nack, output logic [7:0] d, output logic ack_seen);
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, d[i]);
    end
    clock_bit(nack, ack_seen);
  endtask : read_byte

  // A short high spike inside a low phase, sent only where the bench asks.
  task automatic spike_scl(input int w);
    #(HALF_NS / 2) scl_out = 1'b1;
    #(w) scl_out = 1'b0;
    #(HALF_NS / 2);
  endtask : spike_scl
endmodule : two_wire_host

// *** two_wire_link_bench.sv ***
`timescale 1ns/1ns
module two_wire_link_bench;
  logic       ref_clk_in;
  logic       link_clk_in;
  logic       rst_n_in;
  logic       fast_mode_in;
  logic       rx_ready_in;
  logic       tx_valid_in;
  logic [7:0] tx_data_in;
  logic       scl;
  logic       host_sda;
  logic       sda_out;
  logic       sda_oe_n_out;
  logic       rx_valid_out;
  logic [7:0] rx_data_out;
  logic       rx_first_out;
  logic       tx_ready_out;
  logic       bus_idle_out;
  wire        sda_line;
  int         n_mismatch = 0;
  int         n_tests = 0;
  int         cycles = 0;

  // Pull-up wire: whichever party pulls low wins.
  assign sda_line = host_sda & (sda_oe_n_out | sda_out);

  two_wire_link u_dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .link_clk_in(link_clk_in),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
    .fast_mode_in(fast_mode_in), .rx_valid_out(rx_valid_out), .rx_ready_in(rx_ready_in),
    .rx_data_out(rx_data_out), .rx_first_out(rx_first_out), .tx_valid_in(tx_valid_in),
    .tx_ready_out(tx_ready_out), .tx_data_in(tx_data_in), .bus_idle_out(bus_idle_out));
  two_wire_host u_host (.scl_out(scl), .sda_drv_out(host_sda), .sda_in(sda_line));

  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    link_clk_in = 1'b0;
    #13;
    forever #40 link_clk_in = ~link_clk_in;
  end

  task automatic end_of_test();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 95000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_byte

  // A pull-down that moves while the clock is high would fake a Start or Stop.
  always @(sda_oe_n_out) begin
    if (rst_n_in === 1'b1) begin
      chk_bit("scl_at_sda_change", 1'b0, scl);
      chk_bit("sda_out_level", 1'b0, sda_out);
    end
  end

  task automatic get_rx(output logic [7:0] d, output logic f);
    int k;
    k = 0;
    @(negedge ref_clk_in);
    while (rx_valid_out !== 1'b1 && k < 2000) begin
      @(negedge ref_clk_in);
      k++;
    end
    d = rx_data_out;
    f = rx_first_out;
    rx_ready_in = 1'b1;
    @(negedge ref_clk_in);
    rx_ready_in = 1'b0;
  endtask : get_rx

  task automatic put_tx(input logic [7:0] d);
    int k;
    k = 0;
    @(negedge ref_clk_in);
    while (tx_ready_out !== 1'b1 && k < 1000) begin
      @(negedge ref_clk_in);
      k++;
    end
    tx_valid_in = 1'b1;
    tx_data_in = d;
    @(negedge ref_clk_in);
    tx_valid_in = 1'b0;
  endtask : put_tx

  task automatic write_pair();
    logic ack;
    logic [7:0] d;
    logic f;
    u_host.start_cond();
    u_host.write_byte(8'hA5, ack);
    chk_bit("ack_first", 1'b0, ack);
    chk_bit("idle_in_frame", 1'b0, bus_idle_out);
    u_host.write_byte(8'h3C, ack);
    chk_bit("ack_second", 1'b0, ack);
    u_host.stop_cond();
    #2000;
    chk_bit("idle_after_stop", 1'b1, bus_idle_out);
    get_rx(d, f);
    chk_byte("rx_first_byte", 8'hA5, d);
    chk_bit("first_flag", 1'b1, f);
    get_rx(d, f);
    chk_byte("rx_second_byte", 8'h3C, d);
    chk_bit("second_flag", 1'b0, f);
  endtask : write_pair

  task automatic abort_mid_byte();
    logic ack;
    logic [7:0] d;
    logic f;
    u_host.start_cond();
    u_host.send_bits(8'h0A, 4);
    u_host.start_cond();
    u_host.write_byte(8'h5A, ack);
    chk_bit("ack_after_restart", 1'b0, ack);
    u_host.stop_cond();
    get_rx(d, f);
    chk_byte("rx_after_restart", 8'h5A, d);
    chk_bit("first_after_restart", 1'b1, f);
    #1000;
    chk_bit("no_partial_byte", 1'b0, rx_valid_out);
  endtask : abort_mid_byte

  task automatic read_nack();
    logic ack;
    logic [7:0] d;
    logic f;
    put_tx(8'h96);
    u_host.start_cond();
    u_host.write_byte(8'hA1, ack);
    chk_bit("ack_addr", 1'b0, ack);
    u_host.read_byte(1'b1, d, ack);
    chk_byte("tx_byte", 8'h96, d);
    chk_bit("ack_slot_free", 1'b1, ack);
    #1000;
    chk_bit("release_after_nack", 1'b1, sda_oe_n_out);
    u_host.stop_cond();
    get_rx(d, f);
    chk_byte("rx_addr", 8'hA1, d);
    chk_bit("first_addr", 1'b1, f);
  endtask : read_nack

  // The host stalls mid-read, then frees the line with dummy clocks.
  task automatic recover_bus();
    logic ack;
    logic [7:0] d;
    logic f;
    int n;
    put_tx(8'h00);
    u_host.start_cond();
    u_host.write_byte(8'hA3, ack);
    u_host.send_bits(8'hFF, 3);
    n = 0;
    ack = 1'b0;
    while (ack !== 1'b1 && n < 9) begin
      u_host.clock_bit(1'b1, ack);
      n++;
    end
    chk_bit("released_in_nine", 1'b1, ack);
    chk_byte("dummy_clocks", 8'h06, 8'(n));
    u_host.start_cond();
    u_host.stop_cond();
    get_rx(d, f);
    chk_byte("rx_before_recover", 8'hA3, d);
  endtask : recover_bus

  // Spike width sits exactly at the rejection limit of the chosen mode.
  task automatic glitch_rejected(input logic fast, input int w);
    logic ack;
    logic [7:0] d;
    logic f;
    @(negedge ref_clk_in);
    fast_mode_in = fast;
    #1000;
    u_host.start_cond();
    u_host.send_bits(8'h0C, 4);
    u_host.spike_scl(w);
    u_host.send_bits(8'h03, 4);
    u_host.clock_bit(1'b1, ack);
    chk_bit("ack_after_spike", 1'b0, ack);
    u_host.stop_cond();
    get_rx(d, f);
    chk_byte("rx_after_spike", 8'hC3, d);
  endtask : glitch_rejected

  task automatic ignore_in_reset();
    logic ack;
    @(negedge ref_clk_in);
    rst_n_in = 1'b0;
    u_host.start_cond();
    u_host.write_byte(8'hA5, ack);
    chk_bit("ack_in_reset", 1'b1, ack);
    u_host.stop_cond();
    chk_bit("rx_valid_in_reset", 1'b0, rx_valid_out);
    @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    #2000;
    chk_bit("idle_after_reset", 1'b1, bus_idle_out);
  endtask : ignore_in_reset

  task automatic fifo_full();
    logic ack;
    logic [7:0] d;
    logic f;
    u_host.start_cond();
    // Nothing is drained, so 32 words plus the read register fill before the refusal.
    for (int i = 0; i < 34; i++) begin
      u_host.write_byte(8'h40 + i[7:0], ack);
      chk_bit("ack_fill", (i < 33) ? 1'b0 : 1'b1, ack);
    end
    u_host.stop_cond();
    for (int i = 0; i < 33; i++) begin
      get_rx(d, f);
      chk_byte("rx_fill", 8'h40 + i[7:0], d);
      chk_bit("first_fill", i == 0, f);
    end
    #1000;
    chk_bit("rx_drained", 1'b0, rx_valid_out);
  endtask : fifo_full

  initial begin
    rst_n_in = 1'b0;
    fast_mode_in = 1'b0;
    rx_ready_in = 1'b0;
    tx_valid_in = 1'b0;
    tx_data_in = 8'h00;
    // Held over link edges too, since the link domain needs two of them.
    repeat (3) @(posedge link_clk_in);
    @(negedge ref_clk_in);
    chk_bit("oe_n_in_reset", 1'b1, sda_oe_n_out);
    chk_bit("tx_ready_in_reset", 1'b0, tx_ready_out);
    rst_n_in = 1'b1;
    #100000;
    chk_bit("idle_at_start", 1'b1, bus_idle_out);
    chk_bit("tx_ready_after_reset", 1'b1, tx_ready_out);
    write_pair();
    abort_mid_byte();
    read_nack();
    recover_bus();
    glitch_rejected(1'b0, 100);
    glitch_rejected(1'b1, 50);
    ignore_in_reset();
    fifo_full();
    end_of_test();
  end
endmodule : two_wire_link_bench
